// ===== usbdc_pkg.sv
// usbdc_pkg: offsets, field positions and reset values of the
// usb function and dma channel configuration bank.
// assumes an 8-bit mcu data bus with 16-bit byte addresses.
package usbdc_pkg;

	localparam int NUM_CHAN = 4;
	localparam int SLOT_COUNT = 14;

	// usb function registers
	localparam logic [15:0] IRQ_MASK_OFS = 16'hFFFD;
	localparam logic [15:0] USB_CTL_OFS = 16'hFFFC;
	localparam logic [15:0] FRAME_LOW_OFS = 16'hFFFB;
	localparam logic [15:0] FRAME_HIGH_OFS = 16'hFFFA;

	// per channel registers, channel 3 in the top slot
	localparam logic [3:0][15:0] SLOT_LOW_OFS =
		{16'hFFF9, 16'hFFF6, 16'hFFF0, 16'hFFEA};
	localparam logic [3:0][15:0] SLOT_HIGH_OFS =
		{16'hFFF8, 16'hFFF5, 16'hFFEF, 16'hFFE9};
	localparam logic [3:0][15:0] CHAN_CTL_OFS =
		{16'hFFF7, 16'hFFF4, 16'hFFEE, 16'hFFE8};

	// usb control fields
	localparam int CONNECT_BIT = 7;
	localparam int RESPOND_BIT = 6;
	localparam int WAKE_BIT = 5;
	localparam int SCOPE_BIT = 4;
	localparam logic [7:0] USB_CTL_WMASK = 8'hF0;
	localparam logic [7:0] USB_CTL_KEEP = 8'h90;

	// interrupt mask fields
	localparam int OVERWRITE_MASK_BIT = 0;
	localparam logic [7:0] IRQ_MASK_WMASK = 8'hFD;

	// frame number fields
	localparam int FRAME_BITS = 11;
	localparam logic [7:0] FRAME_HIGH_RMASK = 8'h07;

	// slot high fields
	localparam int WIDTH_LSB = 6;
	localparam logic [7:0] SLOT_HIGH_SEL_MASK = 8'h3F;

	// channel control fields
	localparam int CHAN_ENABLE_BIT = 7;
	localparam int WRAP_BIT = 6;
	localparam int DIR_BIT = 3;
	localparam logic [7:0] CHAN_CTL_WMASK = 8'hCF;
	localparam logic [7:0] EP_MASK = 8'h07;

	localparam logic [7:0] REG_RESET = 8'h00;

endpackage

// ===== usbdc_chan.sv
// usbdc_chan: one dma channel's slot matcher; turns a codec slot
// strobe into a transfer request for this channel's endpoint.
// assumes slot strobes are one-cycle pulses synchronous to mclk.
`timescale 1ns/1ps
module usbdc_chan (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       arst_n,
	// configuration from the register bank
	input  wire logic [13:0] slot_select,
	input  wire logic [1:0]  bytes_per_slot,
	input  wire logic        channel_enable,
	input  wire logic        wrap_buffer_enable,
	input  wire logic        endpoint_direction,
	input  wire logic [2:0]  endpoint_select,
	// codec slot timing
	input  wire logic        slot_strobe,
	input  wire logic [3:0]  slot_index,
	// transfer request to the mover
	output logic             xfer_req,
	output logic [2:0]       xfer_bytes,
	output logic             xfer_in,
	output logic [2:0]       xfer_ep,
	output logic             xfer_wrap
);

	typedef struct packed {
		logic       req;
		logic [2:0] bytes;
		logic       dir_in;
		logic [2:0] ep;
		logic       wrap;
	} usbdc_chan_state_type;

	usbdc_chan_state_type s;
	usbdc_chan_state_type next_s;
	logic                 selected;

	always_comb begin
		next_s = s;
		next_s.req = 1'b0;
		// slots 14 and 15 do not exist and never match
		selected = (slot_index < 4'hE) && slot_select[slot_index];
		// endpoint 0 belongs to the mcu, never to a channel
		if (slot_strobe && channel_enable && selected &&
				endpoint_select != 3'h0) begin
			next_s.req = 1'b1;
			next_s.bytes = {1'b0, bytes_per_slot} + 3'h1;
			next_s.dir_in = endpoint_direction;
			next_s.ep = endpoint_select;
			next_s.wrap = wrap_buffer_enable;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign xfer_req = s.req;
	assign xfer_bytes = s.bytes;
	assign xfer_in = s.dir_in;
	assign xfer_ep = s.ep;
	assign xfer_wrap = s.wrap;

endmodule

// ===== usbdc_regs.sv
// usbdc_regs: usb function control and dma channel configuration
// register bank on the mcu data bus, with four channel matchers.
// assumes mcu strobes and usb events are synchronous to mclk.
//
// Functional notes
// - mask bit 0 gates setup overwrite interrupt
// - connect bit drives data-plus pullup, else hi-z
// - connect bit survives usb bus reset
// - respond enable gates transactions, cleared by reset
// - remote wake bit requests upstream resume signaling
// - scoped bus reset clears all but connect and scope
// - scoped bus reset drives reset output pin
// - scope bit kept; control bits 3:0 read-only
// - frame number loaded from each sof packet
// - unlocked timer increments frame on pseudo sof
// - four channels, three registers each
// - fourteen slot select bits per channel
// - enabled channel moves data for selected slots
// - transfer direction follows endpoint direction bit
// - control bit 7 enables the channel
// - control bit 6 enables wrap-around buffering
// - bit 3 selects in or out; 5:4 reserved
// - bits 2:0 select endpoint 1 to 7
`timescale 1ns/1ps
module usbdc_regs (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// mcu data bus
	input  wire logic [15:0] mcu_addr,
	input  wire logic [7:0]  mcu_wdata,
	input  wire logic        mcu_wr,
	input  wire logic        mcu_rd,
	output logic [7:0]       mcu_rdata,
	output logic             mcu_hit,
	// usb engine events
	input  wire logic        usb_bus_reset,
	input  wire logic        sof_valid,
	input  wire logic [10:0] sof_frame,
	input  wire logic        pseudo_frame_start,
	input  wire logic        frame_timer_locked,
	input  wire logic        setup_overwrite_flag,
	// usb control outputs
	output logic             dplus_pullup_out,
	output logic             dplus_pullup_oe,
	output logic             function_respond_enable,
	output logic             remote_wake_request,
	output logic             reset_out_pin,
	output logic             system_reset_req,
	output logic             setup_overwrite_irq,
	// codec slot timing
	input  wire logic        slot_strobe,
	input  wire logic [3:0]  slot_index,
	// per channel transfer requests
	output logic [3:0]       xfer_req,
	output logic [3:0][2:0]  xfer_bytes,
	output logic [3:0]       xfer_in,
	output logic [3:0][2:0]  xfer_ep,
	output logic [3:0]       xfer_wrap,
	output logic [3:0]       wrap_buffer_enable
);

	typedef struct packed {
		logic [7:0]      usb_ctl;
		logic [7:0]      irq_mask;
		logic [10:0]     frame_count;
		logic [3:0][7:0] slot_low;
		logic [3:0][7:0] slot_high;
		logic [3:0][7:0] chan_ctl;
		logic [7:0]      rdata;
		logic            hit;
		logic            rst_out;
		logic            irq;
	} usbdc_regs_state_type;

	usbdc_regs_state_type s;
	usbdc_regs_state_type next_s;
	logic                 scoped_reset;

	// returns the channel whose register sits at addr, if any
	function automatic logic [2:0] chan_lookup(
		input logic [15:0]      addr,
		input logic [3:0][15:0] table_ofs
	);
		logic [2:0] res;
		res = 3'h0;
		for (int i = 0; i < usbdc_pkg::NUM_CHAN; i++) begin
			if (addr == table_ofs[i]) begin
				res = {1'b1, 2'(i)};
			end
		end
		return res;
	endfunction

	// read value of any mapped register; unmapped reads give zero
	function automatic logic [8:0] read_value(
		input usbdc_regs_state_type st,
		input logic [15:0]          addr
	);
		logic [2:0] lo;
		logic [2:0] hi;
		logic [2:0] ct;
		logic [8:0] res;
		lo = chan_lookup(addr, usbdc_pkg::SLOT_LOW_OFS);
		hi = chan_lookup(addr, usbdc_pkg::SLOT_HIGH_OFS);
		ct = chan_lookup(addr, usbdc_pkg::CHAN_CTL_OFS);
		res = {1'b0, usbdc_pkg::REG_RESET};
		if (addr == usbdc_pkg::IRQ_MASK_OFS) begin
			res = {1'b1, st.irq_mask};
		end else if (addr == usbdc_pkg::USB_CTL_OFS) begin
			res = {1'b1, st.usb_ctl};
		end else if (addr == usbdc_pkg::FRAME_LOW_OFS) begin
			res = {1'b1, st.frame_count[7:0]};
		end else if (addr == usbdc_pkg::FRAME_HIGH_OFS) begin
			res = {1'b1, 5'h00, st.frame_count[10:8]};
		end else if (lo[2]) begin
			res = {1'b1, st.slot_low[lo[1:0]]};
		end else if (hi[2]) begin
			res = {1'b1, st.slot_high[hi[1:0]]};
		end else if (ct[2]) begin
			res = {1'b1, st.chan_ctl[ct[1:0]]};
		end
		return res;
	endfunction

	always_comb begin
		logic [2:0] lo;
		logic [2:0] hi;
		logic [2:0] ct;
		lo = chan_lookup(mcu_addr, usbdc_pkg::SLOT_LOW_OFS);
		hi = chan_lookup(mcu_addr, usbdc_pkg::SLOT_HIGH_OFS);
		ct = chan_lookup(mcu_addr, usbdc_pkg::CHAN_CTL_OFS);
		next_s = s;
		scoped_reset = usb_bus_reset &&
			s.usb_ctl[usbdc_pkg::SCOPE_BIT];

		// firmware writes; reserved bits are masked to zero
		if (mcu_wr) begin
			if (mcu_addr == usbdc_pkg::IRQ_MASK_OFS) begin
				next_s.irq_mask =
					mcu_wdata & usbdc_pkg::IRQ_MASK_WMASK;
			end else if (mcu_addr == usbdc_pkg::USB_CTL_OFS) begin
				next_s.usb_ctl =
					mcu_wdata & usbdc_pkg::USB_CTL_WMASK;
			end else if (lo[2]) begin
				next_s.slot_low[lo[1:0]] = mcu_wdata;
			end else if (hi[2]) begin
				next_s.slot_high[hi[1:0]] = mcu_wdata;
			end else if (ct[2]) begin
				next_s.chan_ctl[ct[1:0]] =
					mcu_wdata & usbdc_pkg::CHAN_CTL_WMASK;
			end
		end

		// frame number is hardware owned, sof load beats increment
		if (sof_valid) begin
			next_s.frame_count = sof_frame;
		end else if (pseudo_frame_start && !frame_timer_locked) begin
			next_s.frame_count = 11'(s.frame_count + 11'h001);
		end

		// bus reset overrides a same-cycle write of the respond bit; scoped reset overrides all writes
		if (usb_bus_reset) begin
			next_s.usb_ctl[usbdc_pkg::RESPOND_BIT] = 1'b0;
			next_s.frame_count = '0;
			if (scoped_reset) begin
				// connect and scope bits stay, all else cleared
				next_s.usb_ctl = s.usb_ctl &
					usbdc_pkg::USB_CTL_KEEP;
				next_s.irq_mask = usbdc_pkg::REG_RESET;
				next_s.slot_low = '0;
				next_s.slot_high = '0;
				next_s.chan_ctl = '0;
			end
		end
		next_s.rst_out = scoped_reset;

		// setup overwrite interrupt only while unmasked
		next_s.irq = setup_overwrite_flag &&
			s.irq_mask[usbdc_pkg::OVERWRITE_MASK_BIT];

		// read data is registered, valid the cycle after mcu_rd
		if (mcu_rd) begin
			{next_s.hit, next_s.rdata} = read_value(s, mcu_addr);
		end else begin
			next_s.hit = 1'b0;
			next_s.rdata = usbdc_pkg::REG_RESET;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// pullup drives high only while connected, else released
	assign dplus_pullup_out = s.usb_ctl[usbdc_pkg::CONNECT_BIT];
	assign dplus_pullup_oe = s.usb_ctl[usbdc_pkg::CONNECT_BIT];
	assign function_respond_enable =
		s.usb_ctl[usbdc_pkg::RESPOND_BIT];
	// level follows the bit; firmware must drop it quickly
	assign remote_wake_request = s.usb_ctl[usbdc_pkg::WAKE_BIT];
	assign reset_out_pin = s.rst_out;
	assign system_reset_req = s.rst_out;
	assign setup_overwrite_irq = s.irq;
	assign mcu_rdata = s.rdata;
	assign mcu_hit = s.hit;

	// one matcher per channel; slot bits may be changed live but
	// should be set before enable to avoid partial frames
	for (genvar c = 0; c < usbdc_pkg::NUM_CHAN; c++) begin : g_chan
		usbdc_chan u_chan (
			.mclk               (mclk),
			.arst_n             (arst_n),
			.slot_select        ({s.slot_high[c][5:0],
				s.slot_low[c]}),
			.bytes_per_slot     (s.slot_high[c][7:6]),
			.channel_enable     (s.chan_ctl[c][7]),
			.wrap_buffer_enable (s.chan_ctl[c][6]),
			.endpoint_direction (s.chan_ctl[c][3]),
			.endpoint_select    (s.chan_ctl[c][2:0]),
			.slot_strobe        (slot_strobe),
			.slot_index         (slot_index),
			.xfer_req           (xfer_req[c]),
			.xfer_bytes         (xfer_bytes[c]),
			.xfer_in            (xfer_in[c]),
			.xfer_ep            (xfer_ep[c]),
			.xfer_wrap          (xfer_wrap[c])
		);
		// buffer manager also acts on the wrap bit
		assign wrap_buffer_enable[c] =
			s.chan_ctl[c][usbdc_pkg::WRAP_BIT];
	end

endmodule

// ===== usbdc_regs_props.sv
// usbdc_regs_props: port-level checks of the usbdc_regs bank.
// assumes it is bound onto every usbdc_regs instance.
`timescale 1ns/1ps
module usbdc_regs_props (
	// clock and reset
	input wire logic        mclk,
	input wire logic        arst_n,
	// watched ports
	input wire logic [15:0] mcu_addr,
	input wire logic        mcu_wr,
	input wire logic        mcu_rd,
	input wire logic [7:0]  mcu_rdata,
	input wire logic        mcu_hit,
	input wire logic        usb_bus_reset,
	input wire logic        setup_overwrite_flag,
	input wire logic        setup_overwrite_irq,
	input wire logic        dplus_pullup_out,
	input wire logic        dplus_pullup_oe,
	input wire logic        function_respond_enable,
	input wire logic        reset_out_pin,
	input wire logic        system_reset_req,
	input wire logic        slot_strobe,
	input wire logic [3:0]  slot_index,
	input wire logic [3:0]  xfer_req
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	sequence s_ctl_read;
		mcu_rd && mcu_addr == usbdc_pkg::USB_CTL_OFS;
	endsequence
	a_ctl_reserved: assert property (
		s_ctl_read |=> mcu_hit && mcu_rdata[3:0] == 4'h0) else $error("ctl");
	a_read_stands: assert property (
		s_ctl_read ##1 !mcu_rd |=> !mcu_hit) else $error("hit held");
	a_frame_high: assert property (
		mcu_rd && mcu_addr == usbdc_pkg::FRAME_HIGH_OFS
		|=> mcu_hit && mcu_rdata[7:3] == 5'h00) else $error("frame high");
	a_connect_keep: assert property (
		usb_bus_reset && !(mcu_wr && mcu_addr == usbdc_pkg::USB_CTL_OFS)
		|=> $stable(dplus_pullup_out)) else $error("connect lost");
	a_oe_follow: assert property (
		dplus_pullup_oe == dplus_pullup_out) else $error("pullup oe");
	a_respond_clear: assert property (
		usb_bus_reset |=> !function_respond_enable) else $error("respond");
	a_pin_cause: assert property (
		reset_out_pin |-> $past(usb_bus_reset)) else $error("reset pin");
	a_pin_pair: assert property (
		reset_out_pin == system_reset_req) else $error("reset pair");
	a_irq_cause: assert property (
		setup_overwrite_irq |-> $past(setup_overwrite_flag)) else $error("irq");
	a_no_strobe: assert property (
		!slot_strobe |=> xfer_req == 4'h0) else $error("stray req");
	a_bad_slot: assert property (
		slot_strobe && slot_index > 4'hD |=> xfer_req == 4'h0) else $error("slot");
endmodule

bind usbdc_regs usbdc_regs_props u_usbdc_regs_props (.mclk, .arst_n,
	.mcu_addr, .mcu_wr, .mcu_rd, .mcu_rdata, .mcu_hit, .usb_bus_reset,
	.setup_overwrite_flag, .setup_overwrite_irq, .dplus_pullup_out,
	.dplus_pullup_oe, .function_respond_enable, .reset_out_pin,
	.system_reset_req, .slot_strobe, .slot_index, .xfer_req);

// ===== tb_top.sv
// tb_top: self-checking bench for the usbdc_regs bank.
// assumes usbdc_pkg and the bound checker are compiled first.
`timescale 1ns/1ps
module tb_top;
	logic            mclk, arst_n, mcu_wr, mcu_rd, mcu_hit, usb_bus_reset;
	logic            sof_valid, pseudo_frame_start, frame_timer_locked;
	logic            setup_overwrite_flag, slot_strobe, setup_overwrite_irq;
	logic            dplus_pullup_out, dplus_pullup_oe, remote_wake_request;
	logic            function_respond_enable, reset_out_pin, system_reset_req;
	logic [15:0]     mcu_addr;
	logic [7:0]      mcu_wdata, mcu_rdata;
	logic [10:0]     sof_frame;
	logic [3:0]      slot_index, xfer_req, xfer_in, xfer_wrap;
	logic [3:0]      wrap_buffer_enable;
	logic [3:0][2:0] xfer_bytes, xfer_ep;
	int              n_fail, n_checks, fr;
	int              mdl[int];
	int              adr[$];
	usbdc_regs u_usbdc_regs (.mclk, .arst_n, .mcu_addr, .mcu_wdata, .mcu_wr,
		.mcu_rd, .mcu_rdata, .mcu_hit, .usb_bus_reset, .sof_valid, .sof_frame,
		.pseudo_frame_start, .frame_timer_locked, .setup_overwrite_flag,
		.dplus_pullup_out, .dplus_pullup_oe, .function_respond_enable,
		.remote_wake_request, .reset_out_pin, .system_reset_req,
		.setup_overwrite_irq, .slot_strobe, .slot_index, .xfer_req,
		.xfer_bytes, .xfer_in, .xfer_ep, .xfer_wrap, .wrap_buffer_enable);
	task automatic chk(logic [7:0] got, int exp);
		n_checks++;
		if (got !== exp[7:0]) begin
			n_fail++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp[7:0]);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	function automatic int wmask(int a);
		if (a == usbdc_pkg::USB_CTL_OFS) return usbdc_pkg::USB_CTL_WMASK;
		if (a == usbdc_pkg::IRQ_MASK_OFS) return usbdc_pkg::IRQ_MASK_WMASK;
		for (int c = 0; c < 4; c++)
			if (a == usbdc_pkg::CHAN_CTL_OFS[c]) return usbdc_pkg::CHAN_CTL_WMASK;
		return 'hFF;
	endfunction
	task automatic wr(int a, int d);
		mcu_addr = a[15:0];
		mcu_wdata = d[7:0];
		mcu_wr = 1;
		@(posedge mclk); #1;
		mcu_wr = 0;
		if (mdl.exists(a)) mdl[a] = d & wmask(a);
		// idle edge so a following call never re-raises the strobe at once
		@(posedge mclk); #1;
	endtask
	task automatic rd(int a);
		int e;
		e = mdl.exists(a) ? mdl[a] : 0;
		if (a == usbdc_pkg::FRAME_LOW_OFS) e = fr & 'hFF;
		if (a == usbdc_pkg::FRAME_HIGH_OFS) e = (fr >> 8) & 7;
		mcu_addr = a[15:0];
		mcu_rd = 1;
		@(posedge mclk); #1;
		mcu_rd = 0;
		chk(mcu_rdata, e);
		chk(mcu_hit, mdl.exists(a) || (a >> 1) == 'h7FFD);
		@(posedge mclk); #1;
	endtask
	task automatic outs();
		int u;
		u = mdl[usbdc_pkg::USB_CTL_OFS];
		chk(dplus_pullup_out, u[7]);
		chk(dplus_pullup_oe, u[7]);
		chk(function_respond_enable, u[6]);
		chk(remote_wake_request, u[5]);
	endtask
	task automatic busrst();
		int sc;
		sc = mdl[usbdc_pkg::USB_CTL_OFS] >> 4 & 1;
		usb_bus_reset = 1;
		@(posedge mclk); #1;
		usb_bus_reset = 0;
		fr = 0;
		mdl[usbdc_pkg::USB_CTL_OFS] &= sc ? 'h90 : 'hB0;
		foreach (adr[i])
			if (sc && (adr[i] < 'hFFFA || adr[i] == 'hFFFD)) mdl[adr[i]] = 0;
		chk(reset_out_pin, sc);
		chk(system_reset_req, sc);
		outs();
		foreach (adr[i]) rd(adr[i]);
	endtask
	task automatic frm(int sof, int ps, int lk);
		sof_valid = sof >= 0;
		sof_frame = sof[10:0];
		pseudo_frame_start = ps[0];
		frame_timer_locked = lk[0];
		@(posedge mclk); #1;
		{sof_valid, pseudo_frame_start} = 0;
		if (sof >= 0) fr = sof;
		else if (ps && !lk) fr = (fr + 1) & 'h7FF;
		rd(usbdc_pkg::FRAME_LOW_OFS);
		rd(usbdc_pkg::FRAME_HIGH_OFS);
	endtask
	task automatic chan(int c, int sel, int w, int ctl);
		logic req;
		wr(usbdc_pkg::SLOT_LOW_OFS[c], sel);
		wr(usbdc_pkg::SLOT_HIGH_OFS[c], w << 6 | sel >> 8 & 'h3F);
		wr(usbdc_pkg::CHAN_CTL_OFS[c], ctl);
		slot_strobe = 1;
		for (int i = 0; i < 16; i++) begin
			slot_index = i[3:0];
			@(posedge mclk); #1;
			req = ctl[7] && (ctl & 7) != 0 && i < 14 && sel[i];
			chk(xfer_req[c], req);
			if (req) begin
				chk(xfer_bytes[c], w + 1);
				chk(xfer_in[c], ctl[3]);
				chk(xfer_ep[c], ctl & 7);
				chk(xfer_wrap[c], ctl[6]);
			end
		end
		slot_strobe = 0;
		chk(wrap_buffer_enable[c], ctl[6]);
	endtask
	initial begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		report_and_stop();
	end
	initial begin
		{arst_n, mcu_wr, mcu_rd, usb_bus_reset, sof_valid, slot_strobe} = 0;
		{pseudo_frame_start, frame_timer_locked, setup_overwrite_flag} = 0;
		{mcu_addr, mcu_wdata, sof_frame, slot_index} = 0;
		void'($urandom(36));
		adr = {'hFFFD, 'hFFFC};
		for (int c = 0; c < 4; c++) begin
			adr.push_back(usbdc_pkg::SLOT_LOW_OFS[c]);
			adr.push_back(usbdc_pkg::SLOT_HIGH_OFS[c]);
			adr.push_back(usbdc_pkg::CHAN_CTL_OFS[c]);
		end
		foreach (adr[i]) mdl[adr[i]] = 0;
		adr.push_back('hFFFB);
		adr.push_back('hFFFA);
		repeat (10) @(posedge mclk);
		#1 arst_n = 1;
		foreach (adr[i]) rd(adr[i]);
		rd('hFFF1);
		rd('hFFFF);
		foreach (adr[i]) wr(adr[i], $urandom);
		foreach (adr[i]) rd(adr[i]);
		outs();
		setup_overwrite_flag = 1;
		for (int m = 0; m < 2; m++) begin
			wr('hFFFD, m);
			@(posedge mclk); #1;
			chk(setup_overwrite_irq, m);
		end
		wr('hFFFC, 'hE0);
		busrst();
		// firmware drops the wake request well inside its time limit
		wr('hFFFC, 'hC0);
		outs();
		for (int c = 0; c < 4; c++)
			chan(c, $urandom, c, 'h80 | $urandom & 'h48 | 1 + $urandom % 7);
		chan(0, 'h3FFF, 3, 'h88);
		chan(1, $urandom, 1, 'h0F);
		frm($urandom & 'h7FF, 0, 0);
		frm(-1, 1, 0);
		frm(-1, 1, 1);
		frm('h7FF, 1, 0);
		frm(-1, 1, 0);
		wr('hFFFC, 'hF0);
		busrst();
		report_and_stop();
	end
endmodule
